// File: rtl/tlp_receive_stream_source.sv
// Receive stream source: ready-latency handshake, qword realignment, parity
`timescale 1ns/1ps
`default_nettype none
module tlp_receive_stream_source #(
    parameter bit PARITY_EN = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [rx_stream_pkg::DATA_W-1:0] in_data,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [rx_stream_pkg::DWS_W-1:0] in_last_dws,
    input wire logic in_err,
    output logic [rx_stream_pkg::DATA_W-1:0] recv_bus_word,
    output logic recv_first_beat,
    output logic recv_last_beat,
    output logic recv_beat_qualifier,
    input wire logic recv_sink_accept,
    output logic [rx_stream_pkg::BYTES-1:0] recv_byte_odd_check,
    output logic [rx_stream_pkg::EMPTY_W-1:0] recv_unused_qwords,
    output logic recv_packet_fault
);
    typedef struct packed {
        logic rdy;
        logic valid;
        logic sop;
        logic eop;
        logic [rx_stream_pkg::EMPTY_W-1:0] empty;
        logic err;
        logic [rx_stream_pkg::DATA_W-1:0] data;
        logic [rx_stream_pkg::DWORD_W-1:0] carry;
        logic shift;
        logic tail;
        logic pkt_err;
        logic in_pkt;
    } state_t;

    state_t q;
    state_t n;
    logic fire_in;
    logic pad;
    logic sh;
    logic err_now;
    logic [rx_stream_pkg::BYTES-1:0] par_calc;

    // Only a held ready makes the next registered beat land in a ready cycle
    assign in_ready = q.rdy && !q.tail;
    assign fire_in = in_valid && in_ready;

    // Non-message three-dword header with data and even address gets one pad dword
    assign pad = in_sop && in_data[rx_stream_pkg::FMT_DATA_BIT]
        && !in_data[rx_stream_pkg::FMT_4DW_BIT]
        && (in_data[rx_stream_pkg::TYPE_HI_BIT:rx_stream_pkg::TYPE_LO_BIT] != rx_stream_pkg::TYPE_MSG)
        && !in_data[rx_stream_pkg::ADDR_QW_BIT];
    assign sh = in_sop ? pad : q.shift;
    assign err_now = in_err || (!in_sop && q.pkt_err);

    always_comb
    begin
        n = q;
        n.rdy = recv_sink_accept;
        n.valid = 1'b0;
        n.sop = 1'b0;
        n.eop = 1'b0;
        n.empty = '0;
        n.err = 1'b0;
        if (q.rdy && q.tail)
        begin
            // Spill beat holds the single dword pushed out by the pad
            n.valid = 1'b1;
            n.eop = 1'b1;
            n.data = {{(rx_stream_pkg::DATA_W-rx_stream_pkg::DWORD_W){1'b0}}, q.carry};
            n.empty = rx_stream_pkg::qw_empty(4'h1);
            n.err = q.pkt_err;
            n.tail = 1'b0;
            n.pkt_err = 1'b0;
            n.in_pkt = 1'b0;
            n.shift = 1'b0;
        end
        else if (fire_in)
        begin
            n.valid = 1'b1;
            n.sop = in_sop;
            n.err = err_now;
            n.shift = sh;
            n.carry = in_data[rx_stream_pkg::DATA_W-1 -: rx_stream_pkg::DWORD_W];
            if (in_sop)
            begin
                n.data = pad ? {in_data[rx_stream_pkg::DATA_W-rx_stream_pkg::DWORD_W-1:rx_stream_pkg::HDR3_SPLIT],
                    {rx_stream_pkg::DWORD_W{1'b0}}, in_data[rx_stream_pkg::HDR3_SPLIT-1:0]} : in_data;
            end
            else
            begin
                n.data = q.shift ? {in_data[rx_stream_pkg::DATA_W-rx_stream_pkg::DWORD_W-1:0], q.carry} : in_data;
            end
            if (in_eop && sh && in_last_dws == rx_stream_pkg::FULL_DWS)
            begin
                // Shifted last dword overflows: close the packet on a spill beat
                n.tail = 1'b1;
                n.pkt_err = err_now;
                n.in_pkt = 1'b1;
            end
            else if (in_eop)
            begin
                n.eop = 1'b1;
                n.empty = rx_stream_pkg::qw_empty(sh ? in_last_dws + 4'h1 : in_last_dws);
                n.pkt_err = 1'b0;
                n.in_pkt = 1'b0;
            end
            else
            begin
                n.pkt_err = err_now;
                n.in_pkt = 1'b1;
            end
        end
        if (!rst_b)
        begin
            n = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        q <= n;
    end

    odd_parity_gen #(
        .BYTES(rx_stream_pkg::BYTES)
    ) u_parity (
        .data(q.data),
        .parity(par_calc)
    );

    // Parity is a pure function of the data flops, so it tracks them with no extra stage
    assign recv_byte_odd_check = PARITY_EN ? par_calc : '0;
    assign recv_bus_word = q.data;
    assign recv_first_beat = q.sop;
    assign recv_last_beat = q.eop;
    assign recv_beat_qualifier = q.valid;
    assign recv_unused_qwords = q.empty;
    assign recv_packet_fault = q.err;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_valid_ready_cycle: assert property (recv_beat_qualifier |-> $past(recv_sink_accept, 2))
        else $error("valid outside a ready cycle");
    a_stop_after_drop: assert property (!recv_sink_accept |-> ##2 !recv_beat_qualifier)
        else $error("valid not dropped two clocks after ready fell");
    a_resume_pending: assert property (recv_sink_accept ##1 (in_valid && !q.tail) |-> ##1 recv_beat_qualifier)
        else $error("valid not resumed with data pending");
    a_markers_need_valid: assert property ((recv_first_beat || recv_last_beat) |-> recv_beat_qualifier)
        else $error("packet marker without valid");
    a_packet_opens_sop: assert property (recv_beat_qualifier && !$past(q.in_pkt) |-> recv_first_beat)
        else $error("packet did not open with first beat");
    a_no_sop_inside: assert property (recv_beat_qualifier && $past(q.in_pkt) |-> !recv_first_beat)
        else $error("first beat inside open packet");
    a_parity_low_byte: assert property (PARITY_EN && recv_beat_qualifier
        |-> (^{recv_byte_odd_check[0], recv_bus_word[7:0]}) && (^{recv_byte_odd_check[31], recv_bus_word[255:248]}))
        else $error("byte parity not odd");
    a_parity_off_quiet: assert property (!PARITY_EN |-> recv_byte_odd_check == '0)
        else $error("parity driven while disabled");
    a_empty_mid_packet: assert property (recv_beat_qualifier && !recv_last_beat |-> recv_unused_qwords == 2'h0)
        else $error("empty field set outside packet end");
    a_pad_inserted: assert property (fire_in && pad |-> ##1 recv_bus_word[127:96] == 32'h0 && recv_first_beat)
        else $error("pad dword missing for aligned address");
    a_fault_follows: assert property (fire_in && in_err |-> ##1 recv_packet_fault)
        else $error("fault flag not raised");
    a_spill_closes: assert property (q.rdy && q.tail |=> recv_last_beat && recv_unused_qwords == 2'h3)
        else $error("spill beat did not close packet");
    a_fault_fresh_packet: assert property (fire_in && in_sop && !in_err |=> !recv_packet_fault)
        else $error("fault flag leaked into clean packet");
    a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0)
        !rst_b |=> !recv_beat_qualifier && !recv_first_beat && !recv_last_beat)
        else $error("stream active during reset");

    c_single_beat: cover property (recv_first_beat && recv_last_beat);
    c_padded_packet: cover property (fire_in && pad);
    c_spill_beat: cover property (recv_last_beat && q.in_pkt == 1'b0 && $past(q.tail));
    c_stall_resume: cover property (recv_beat_qualifier ##1 !recv_beat_qualifier ##1 recv_beat_qualifier);
endmodule
`default_nettype wire

// File: rtl/rx_stream_pkg.sv
// Shared constants and helpers for the receive stream source
// Contract
// - Drive 256-bit data, meaningful only while valid
// - First-beat marker only on first valid beat
// - Last-beat marker only on final valid beat
// - Every valid cycle is an accepted word
// - Ready in cycle n makes n+2 ready
// - Valid only in ready cycles
// - Valid stops within two clocks of drop
// - Valid resumes within two clocks when pending
// - Messages use four-dword header layout
// - First payload dword placed by qword alignment
// - Parity output only when build option enabled
// - Each parity bit is odd over byte
// - Parity bit k covers byte k
// - Empty field counts unused top quadwords
// - Fault flag during errored packet transfer
package rx_stream_pkg;
    localparam int DATA_W = 256;
    localparam int DWORD_W = 32;
    localparam int BYTE_W = 8;
    localparam int BYTES = DATA_W / BYTE_W;
    localparam int DWS_W = 4;
    localparam int EMPTY_W = 2;
    localparam int HANDSHAKE_DELAY = 2;
    localparam logic [DWS_W-1:0] FULL_DWS = 4'h8;
    localparam logic [DWS_W-1:0] QWORDS_PER_BEAT = 4'h4;
    // Header field positions in dword 0 and the low address bit of a three-dword header
    localparam int FMT_DATA_BIT = 30;
    localparam int FMT_4DW_BIT = 29;
    localparam int TYPE_HI_BIT = 28;
    localparam int TYPE_LO_BIT = 27;
    localparam logic [1:0] TYPE_MSG = 2'h2;
    localparam int ADDR_QW_BIT = 66;
    localparam int HDR3_SPLIT = 96;

    // Unused quadwords above the last valid dword of a beat
    function automatic logic [EMPTY_W-1:0] qw_empty(input logic [DWS_W-1:0] dws);
        logic [DWS_W-1:0] t;
        t = QWORDS_PER_BEAT - ((dws + 4'h1) >> 1);
        return t[EMPTY_W-1:0];
    endfunction
endpackage

// File: rtl/odd_parity_gen.sv
// Per-byte odd parity generator
`timescale 1ns/1ps
`default_nettype none
module odd_parity_gen #(
    parameter int BYTES = 32
) (
    input wire logic [BYTES*8-1:0] data,
    output logic [BYTES-1:0] parity
);
    always_comb
    begin
        for (int k = 0; k < BYTES; k++)
        begin
            parity[k] = ~^data[8*k +: 8];
        end
    end
endmodule
`default_nettype wire

// File: dv/app_sink.sv
// Application sink model driving the accept line
`timescale 1ns/1ps
`default_nettype none
module app_sink (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hold_off,
    output logic recv_sink_accept
);
    // Registered so a stall request always reaches the source a full cycle later
    always_ff @(posedge mclk)
    begin
        recv_sink_accept <= rst_b && !hold_off;
    end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the receive stream source
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [255:0] D4 = {{7{32'h1E0B_A5C3}}, 32'h6000_0000};
    localparam logic [255:0] D3 = {{7{32'h1E0B_A5C3}}, 32'h4000_0000};
    // Three-dword message header with data: only the message exclusion keeps it unpadded
    localparam logic [255:0] DM = {{7{32'h1E0B_A5C3}}, 32'h5000_0000};
    logic mclk = 1'b0, rst_b = 1'b0, hold_off = 1'b0, sink_ok, in_ready, first, last, qual, fault;
    logic in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0, in_err = 1'b0;
    logic [255:0] in_data = '0, word, w0;
    logic [3:0] in_last_dws = 4'h1;
    logic [31:0] par, ep;
    logic [1:0] empty, emp;
    int miscompares = 0, total_checks = 0, nb = 0, nf = 0;
    app_sink app_sink_i (.mclk(mclk), .rst_b(rst_b), .hold_off(hold_off), .recv_sink_accept(sink_ok));
    tlp_receive_stream_source tlp_receive_stream_source_i (.mclk(mclk), .rst_b(rst_b), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .in_last_dws(in_last_dws),
        .in_err(in_err), .recv_bus_word(word), .recv_first_beat(first), .recv_last_beat(last),
        .recv_beat_qualifier(qual), .recv_sink_accept(sink_ok), .recv_byte_odd_check(par),
        .recv_unused_qwords(empty), .recv_packet_fault(fault));
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        total_checks++;
        if (got !== exp)
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            miscompares++;
    endtask
    // Sampled mid-cycle so registered outputs have settled
    always @(negedge mclk)
    begin
        if (qual === 1'b1)
        begin
            for (int k = 0; k < 32; k++)
                ep[k] = ~^word[8*k +: 8];
            chk(par, ep);
            chk(first, nb == 0);
            if (nb == 0)
                w0 = word;
            nb++;
            nf += int'(fault);
            emp = empty;
        end
    end
    // Holds the beat until a take edge; leaves valid high for back-to-back beats
    task automatic send(input logic [255:0] d, input logic s, input logic e, input logic [3:0] n, input logic r);
        int t;
        t = 0;
        in_data = d;
        in_sop = s;
        in_eop = e;
        in_last_dws = n;
        in_err = r;
        in_valid = 1'b1;
        while (in_ready !== 1'b1 && t < 50)
        begin
            @(posedge mclk);
            #1;
            t++;
        end
        @(posedge mclk);
        #1;
    endtask
    task automatic one_pkt(input logic [255:0] d, input logic [3:0] n, input int enb, input logic [1:0] ee);
        nb = 0;
        nf = 0;
        send(d, 1'b1, 1'b1, n, 1'b0);
        in_valid = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(nb, enb);
        chk(emp, ee);
        chk(nf, 0);
    endtask
    task automatic t_plain;
        one_pkt(D4, 4'h4, 1, 2'h2);
        chk(w0, D4);
    endtask
    task automatic t_pad;
        one_pkt(D3, 4'h8, 2, 2'h3);
        chk(w0[127:96], 0);
        chk(w0[95:0], D3[95:0]);
    endtask
    task automatic t_msg;
        one_pkt(DM, 4'h8, 1, 2'h0);
        chk(w0, DM);
    endtask
    task automatic t_stall;
        nb = 0;
        hold_off = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        in_data = D4;
        in_sop = 1'b1;
        in_err = 1'b0;
        in_eop = 1'b1;
        in_last_dws = 4'h2;
        in_valid = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        chk(nb, 0);
        hold_off = 1'b0;
        // Accept rises one edge later, ready reaches the source one more, take on the third
        repeat (3) @(posedge mclk);
        #1;
        in_valid = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(nb, 1);
    endtask
    task automatic t_fault;
        nb = 0;
        nf = 0;
        send(D4, 1'b1, 1'b0, 4'h8, 1'b1);
        send(D4, 1'b0, 1'b1, 4'h8, 1'b0);
        in_valid = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(nf, 2);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        #1;
        chk({qual, first, last}, 0);
        rst_b = 1'b1;
        @(posedge mclk);
        #1;
        t_plain();
        t_pad();
        t_msg();
        t_stall();
        t_fault();
        tally_and_finish();
    end
    initial
    begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
